//--- inc/hpt_pkg.sv
// Package: constants and types for the health predict and thermal monitor
package hpt_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned SAVE_PERIOD_S   = 3600;
    localparam int unsigned TEMP_PERIOD_S   = 600;
    localparam longint unsigned SAVE_PERIOD_CYC =
        longint'(SAVE_PERIOD_S) * longint'(CLK_HZ);
    localparam longint unsigned TEMP_PERIOD_CYC =
        longint'(TEMP_PERIOD_S) * longint'(CLK_HZ);
    localparam int unsigned DELAY_ONLINE_MS = 210;
    localparam int unsigned DELAY_FULL_MS   = 75;
    localparam longint unsigned DELAY_ONLINE_CYC =
        longint'(DELAY_ONLINE_MS) * longint'(CLK_HZ / 1000);
    localparam longint unsigned DELAY_FULL_CYC =
        longint'(DELAY_FULL_MS) * longint'(CLK_HZ / 1000);
    // ------------------------------------------------------------------
    // Page codes and sense codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  IEC_PAGE        = 8'h1c;
    localparam logic [7:0]  TIMER_LOG_PAGE  = 8'h3e;
    localparam logic [15:0] PARAM_PRIMARY   = 16'h0000;
    localparam logic [15:0] PARAM_REFERENCE = 16'h0001;
    localparam logic [3:0]  METHOD_SENSE    = 4'h1;
    localparam logic [23:0] SENSE_PREDICT   = 24'h015d00;
    localparam logic [23:0] SENSE_TEMP      = 24'h010b01;
    localparam logic [23:0] SENSE_ROUNDED   = 24'h013700;
    // ------------------------------------------------------------------
    // Temperature
    // ------------------------------------------------------------------
    localparam logic [7:0]  TEMP_MAX_C      = 8'h41;
    localparam logic [7:0]  TEMP_MIN_C      = 8'h00;
    localparam logic [7:0]  TRIP_RESET      = 8'h41;
    // ------------------------------------------------------------------
    // Save controller states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SV_IDLE = 3'b001,
        SV_WAIT = 3'b010,
        SV_BUSY = 3'b100
    } hpt_save_state_type;
endpackage : hpt_pkg

//--- rtl/hpt_attr.sv
// One monitored attribute: interval, failure and history counters
`timescale 1ns/10ps
`default_nettype none
module hpt_attr #(
    parameter int unsigned CW = 16
) (
    input  wire logic          i_clock,
    input  wire logic          i_rst_b,
    input  wire logic          i_enable,
    input  wire logic          i_op,
    input  wire logic          i_err,
    input  wire logic [CW-1:0] i_interval,
    input  wire logic [CW-1:0] i_err_limit,
    input  wire logic [CW-1:0] i_predict_limit,
    output logic               o_predict,
    output logic [CW-1:0]      o_history
);
    import hpt_pkg::*;

    logic [CW-1:0] ops_r;
    logic [CW-1:0] errs_r;
    logic [CW-1:0] hist_r;
    logic [CW-1:0] hist_nxt;
    logic [CW-1:0] errs_inc;
    wire           bad_now;
    wire           end_now;

    // ------------------------------------------------------------------
    // Evaluation
    // ------------------------------------------------------------------
    assign errs_inc = errs_r + CW'(i_err);
    // Errors beyond the limit end the interval early as unacceptable
    assign bad_now  = i_enable && (errs_inc > i_err_limit);
    assign end_now  = i_enable && (bad_now ||
                      (i_op && (ops_r + 1'b1 >= i_interval)));
    always_comb
    begin
        hist_nxt = hist_r;
        if (end_now && bad_now && hist_r != '1)
            hist_nxt = hist_r + 1'b1;
        else if (end_now && !bad_now && hist_r != '0)
            hist_nxt = hist_r - 1'b1;
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ops_r  <= '0;
            errs_r <= '0;
            hist_r <= '0;
        end
        else
        begin
            hist_r <= hist_nxt;
            if (end_now)
            begin
                ops_r  <= '0;
                errs_r <= '0;
            end
            else if (i_enable)
            begin
                ops_r  <= ops_r + CW'(i_op);
                errs_r <= errs_inc;
            end
        end
    end

    assign o_history = hist_r;
    assign o_predict = (hist_r >= i_predict_limit);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_clear_after_end;
        @(posedge i_clock) disable iff (!i_rst_b)
        end_now |=> (ops_r == '0 && errs_r == '0);
    endproperty
    a_clear_after_end: assert property (p_clear_after_end)
        else $error("counters not cleared at interval end");

    property p_hist_floor;
        @(posedge i_clock) disable iff (!i_rst_b)
        (end_now && !bad_now && hist_r == '0) |=> hist_r == '0;
    endproperty
    a_hist_floor: assert property (p_hist_floor)
        else $error("history went below zero");

    property p_hist_up;
        @(posedge i_clock) disable iff (!i_rst_b)
        (end_now && bad_now && hist_r != '1) |=>
            hist_r == $past(hist_r) + 1'b1;
    endproperty
    a_hist_up: assert property (p_hist_up)
        else $error("history not incremented on bad interval");

    property p_disabled_hold;
        @(posedge i_clock) disable iff (!i_rst_b)
        !i_enable |=> $stable(ops_r) && $stable(errs_r);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold)
        else $error("counting while monitoring disabled");
endmodule : hpt_attr
`default_nettype wire

//--- rtl/hpt_monitor.sv
// Top of the health predict and thermal monitor
//
// Contract
// - Monitor-disable bit set suspends all predictive monitoring; clear enables it.
// - Online-only mode collects during reads and writes, skips offline measurements.
// - Measure and save hourly, deferred until host idle, stopped by host activity.
// - Rezero forces immediate measure and save and restarts the hourly timer.
// - Time remaining to next scheduled save is returned on log page read.
// - Monitoring never stalls host beyond 210 ms online-only or 75 ms full.
// - Method one plus predictive failure sends failure sense with type in unit field.
// - Reported predictive-failure code survives resets and power cycles via nonvolatile store.
// - Per attribute count operations and errors; errors over threshold mean unacceptable.
// - Every evaluation clears interval and failure counters and starts anew.
// - History counter rises on bad interval, falls on good, floor zero.
// - History reaching predictive threshold signals predictive failure for that attribute.
// - Sample temperature at power-up and every ten minutes after.
// - Sample above an active trip point raises temperature warning sense code.
// - Measured temperature goes in the unit code field of sense data.
// - Warnings only when warning enable set; delivered by the selected method. The code delivers them only as sense data with method 1.
// - Compare each sample with two trip points; first fixed at 65 C.
// - Host writes reference parameter 0001h to set second trip; 0000h is primary.
// - User trip defaults 65 C, range 0 to 65; larger clamps with rounded sense.
// - Temperature above the threatening trip also saves a monitoring data frame.
`timescale 1ns/10ps
`default_nettype none
module hpt_monitor #(
    parameter int unsigned     NATTR   = 4,
    parameter int unsigned     CW      = 16,
    parameter longint unsigned SAVE_CYC = hpt_pkg::SAVE_PERIOD_CYC,
    parameter longint unsigned TEMP_CYC = hpt_pkg::TEMP_PERIOD_CYC,
    parameter longint unsigned STALL_ONLINE_CYC = hpt_pkg::DELAY_ONLINE_CYC,
    parameter longint unsigned STALL_FULL_CYC   = hpt_pkg::DELAY_FULL_CYC
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_b,
    input  wire logic             i_monitor_disable,
    input  wire logic             i_online_only_select,
    input  wire logic [3:0]       i_exception_report_method,
    input  wire logic             i_temp_warning_enable,
    input  wire logic [NATTR-1:0] i_attr_op,
    input  wire logic [NATTR-1:0] i_attr_err,
    input  wire logic [CW-1:0]    i_interval,
    input  wire logic [CW-1:0]    i_err_limit,
    input  wire logic [CW-1:0]    i_predict_limit,
    input  wire logic             i_host_busy,
    input  wire logic             i_rezero_force_save,
    input  wire logic             i_save_done,
    input  wire logic             i_nv_pf_valid,
    input  wire logic [7:0]       i_nv_pf_type,
    input  wire logic             i_nv_trip_valid,
    input  wire logic [7:0]       i_nv_trip,
    input  wire logic [7:0]       i_temp_pin,
    input  wire logic             i_log_write,
    input  wire logic [15:0]      i_log_param,
    input  wire logic [7:0]       i_log_data,
    input  wire logic             i_sense_ack,
    output logic                  o_save_req,
    output logic                  o_offline_run,
    output logic [31:0]           o_time_left,
    output logic                  o_nv_pf_write,
    output logic [7:0]            o_nv_pf_type,
    output logic                  o_nv_trip_write,
    output logic [7:0]            o_user_trip,
    output logic [7:0]            o_temp_sample,
    output logic                  o_sense_valid,
    output logic [23:0]           o_sense_code,
    output logic [7:0]            o_sense_unit,
    output logic                  o_pf_active
);
    import hpt_pkg::*;

    // ------------------------------------------------------------------
    // Attribute counters
    // ------------------------------------------------------------------
    wire              mon_en = !i_monitor_disable;
    logic [NATTR-1:0] pred;
    genvar g;
    generate
        for (g = 0; g < NATTR; g++)
        begin : g_attr
            hpt_attr #(.CW(CW)) u_attr (
                .i_clock         (i_clock),
                .i_rst_b         (i_rst_b),
                .i_enable        (mon_en),
                .i_op            (i_attr_op[g]),
                .i_err           (i_attr_err[g]),
                .i_interval      (i_interval),
                .i_err_limit     (i_err_limit),
                .i_predict_limit (i_predict_limit),
                .o_predict       (pred[g]),
                .o_history       ()
            );
        end
    endgenerate

    // Lowest failing attribute index names the failure type
    function automatic logic [7:0] first_set(input logic [NATTR-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = NATTR - 1; i >= 0; i--)
            if (v[i])
                r = 8'(i + 1);
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers for the sensor pins
    // ------------------------------------------------------------------
    logic [7:0] temp_s1_r;
    logic [7:0] temp_s2_r;
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            temp_s1_r <= 8'h00;
            temp_s2_r <= 8'h00;
        end
        else
        begin
            temp_s1_r <= i_temp_pin;
            temp_s2_r <= temp_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Hourly save scheduler
    // ------------------------------------------------------------------
    localparam int unsigned TW = 38;
    localparam int unsigned SW = 34;
    logic [TW-1:0]      save_cnt_r;
    logic [SW-1:0]      stall_r;
    hpt_save_state_type sv_r;
    hpt_save_state_type sv_nxt;
    logic               temp_save_r;
    wire                hour_due  = (save_cnt_r == '0);
    wire                offline_ok = mon_en && !i_online_only_select;
    wire [SW-1:0]       stall_lim = i_online_only_select ?
                                    SW'(STALL_ONLINE_CYC) : SW'(STALL_FULL_CYC);
    // Running save yields once host work has waited the allowed stall
    wire                stall_out = (stall_r >= stall_lim);

    always_comb
    begin
        sv_nxt = sv_r;
        case (sv_r)
            SV_IDLE:
                if (offline_ok && (hour_due || i_rezero_force_save ||
                                   temp_save_r))
                    sv_nxt = i_rezero_force_save ? SV_BUSY : SV_WAIT;
            SV_WAIT:
                if (!offline_ok)
                    sv_nxt = SV_IDLE;
                else if (!i_host_busy)
                    sv_nxt = SV_BUSY;
            SV_BUSY:
                if (!offline_ok || i_save_done)
                    sv_nxt = SV_IDLE;
                else if (i_host_busy && stall_out)
                    sv_nxt = SV_WAIT;
            default:
                sv_nxt = SV_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sv_r       <= SV_IDLE;
            save_cnt_r <= TW'(SAVE_CYC - 1);
            stall_r    <= '0;
        end
        else
        begin
            sv_r <= sv_nxt;
            if (i_rezero_force_save || hour_due)
                save_cnt_r <= TW'(SAVE_CYC - 1);
            else
                save_cnt_r <= save_cnt_r - 1'b1;
            if (sv_r == SV_BUSY && i_host_busy)
                stall_r <= stall_r + 1'b1;
            else
                stall_r <= '0;
        end
    end

    assign o_save_req    = (sv_r == SV_BUSY);
    assign o_offline_run = (sv_r == SV_BUSY);
    assign o_time_left   = 32'(save_cnt_r / TW'(CLK_HZ));

    // ------------------------------------------------------------------
    // Thermal sampling and trip points
    // ------------------------------------------------------------------
    logic [TW-1:0] temp_cnt_r;
    logic [2:0]    first_r;
    logic [7:0]    trip_r;
    logic [7:0]    samp_r;
    logic          loaded_r;
    // Power-up sample waits two edges so the synchroniser holds the pin
    wire           samp_now = first_r[0] || (temp_cnt_r == '0);
    wire           ref_wr   = i_log_write && (i_log_param == PARAM_REFERENCE);
    wire           ref_big  = (i_log_data > TEMP_MAX_C);
    wire [7:0]     ref_val  = ref_big ? TEMP_MAX_C : i_log_data;
    wire           over_fix = (temp_s2_r > TEMP_MAX_C);
    wire           over_usr = (temp_s2_r > trip_r);

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            temp_cnt_r <= TW'(TEMP_CYC - 1);
            first_r    <= 3'h4;
            samp_r     <= 8'h00;
            trip_r     <= TRIP_RESET;
            loaded_r   <= 1'b0;
        end
        else
        begin
            first_r    <= first_r >> 1;
            temp_cnt_r <= samp_now ? TW'(TEMP_CYC - 1) : temp_cnt_r - 1'b1;
            if (samp_now)
                samp_r <= temp_s2_r;
            loaded_r <= 1'b1;
            // Saved trip point taken once after release, host writes win
            if (ref_wr)
                trip_r <= ref_val;
            else if (!loaded_r && i_nv_trip_valid)
                trip_r <= (i_nv_trip > TEMP_MAX_C) ? TEMP_MAX_C : i_nv_trip;
        end
    end

    assign o_user_trip     = trip_r;
    assign o_temp_sample   = samp_r;
    assign o_nv_trip_write = ref_wr;

    // ------------------------------------------------------------------
    // Sense reporting and predictive failure latch
    // ------------------------------------------------------------------
    logic       pf_r;
    logic [7:0] pf_type_r;
    logic       pf_load_r;
    logic       sense_v_r;
    logic [23:0] sense_c_r;
    logic [7:0] sense_u_r;
    wire        by_sense  = (i_exception_report_method == METHOD_SENSE);
    wire        pf_new    = mon_en && !pf_r && (pred != '0);
    wire        temp_hit  = samp_now && mon_en && i_temp_warning_enable &&
                            (over_fix || over_usr);

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pf_r        <= 1'b0;
            pf_type_r   <= 8'h00;
            pf_load_r   <= 1'b0;
            temp_save_r <= 1'b0;
        end
        else
        begin
            pf_load_r <= 1'b1;
            if (!pf_load_r && i_nv_pf_valid)
            begin
                pf_r      <= 1'b1;
                pf_type_r <= i_nv_pf_type;
            end
            else if (pf_new)
            begin
                pf_r      <= 1'b1;
                pf_type_r <= first_set(pred);
            end
            // Threatening temperature queues a data frame save
            if (temp_hit && over_fix)
                temp_save_r <= 1'b1;
            else if (sv_r == SV_BUSY && i_save_done)
                temp_save_r <= 1'b0;
        end
    end

    assign o_nv_pf_write = pf_new;
    assign o_nv_pf_type  = first_set(pred);
    assign o_pf_active   = pf_r;

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sense_v_r <= 1'b0;
            sense_c_r <= 24'h000000;
            sense_u_r <= 8'h00;
        end
        else if (ref_wr && ref_big)
        begin
            sense_v_r <= 1'b1;
            sense_c_r <= SENSE_ROUNDED;
            sense_u_r <= 8'h00;
        end
        else if (pf_new && by_sense)
        begin
            sense_v_r <= 1'b1;
            sense_c_r <= SENSE_PREDICT;
            sense_u_r <= first_set(pred);
        end
        else if (temp_hit && by_sense)
        begin
            sense_v_r <= 1'b1;
            sense_c_r <= SENSE_TEMP;
            sense_u_r <= temp_s2_r;
        end
        else if (i_sense_ack)
            sense_v_r <= 1'b0;
    end

    assign o_sense_valid = sense_v_r;
    assign o_sense_code  = sense_c_r;
    assign o_sense_unit  = sense_u_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_rezero;
        i_rezero_force_save && offline_ok && sv_r == SV_IDLE;
    endsequence

    property p_rezero_save;
        @(posedge i_clock) disable iff (!i_rst_b)
        s_rezero |=> o_save_req;
    endproperty
    a_rezero_save: assert property (p_rezero_save)
        else $error("rezero did not start a save");

    property p_rezero_timer;
        @(posedge i_clock) disable iff (!i_rst_b)
        i_rezero_force_save |=> save_cnt_r == TW'(SAVE_CYC - 1);
    endproperty
    a_rezero_timer: assert property (p_rezero_timer)
        else $error("rezero did not restart the hourly timer");

    property p_disable_no_save;
        @(posedge i_clock) disable iff (!i_rst_b)
        i_monitor_disable ##1 i_monitor_disable |-> !o_save_req;
    endproperty
    a_disable_no_save: assert property (p_disable_no_save)
        else $error("save while monitoring disabled");

    property p_online_no_offline;
        @(posedge i_clock) disable iff (!i_rst_b)
        i_online_only_select ##1 i_online_only_select |-> !o_offline_run;
    endproperty
    a_online_no_offline: assert property (p_online_no_offline)
        else $error("offline work in online-only mode");

    property p_wait_idle;
        @(posedge i_clock) disable iff (!i_rst_b)
        (sv_r == SV_WAIT && i_host_busy) |=> !o_save_req;
    endproperty
    a_wait_idle: assert property (p_wait_idle)
        else $error("save started while host busy");

    property p_temp_sense;
        @(posedge i_clock) disable iff (!i_rst_b)
        (temp_hit && by_sense && !ref_wr && !pf_new) |=>
            o_sense_valid && o_sense_code == SENSE_TEMP &&
            o_sense_unit == $past(temp_s2_r);
    endproperty
    a_temp_sense: assert property (p_temp_sense)
        else $error("temperature warning not reported");

    property p_trip_clamp;
        @(posedge i_clock) disable iff (!i_rst_b)
        ref_wr |=> o_user_trip <= TEMP_MAX_C;
    endproperty
    a_trip_clamp: assert property (p_trip_clamp)
        else $error("user trip above limit");

    property p_pf_sticky;
        @(posedge i_clock) disable iff (!i_rst_b)
        o_pf_active |=> o_pf_active;
    endproperty
    a_pf_sticky: assert property (p_pf_sticky)
        else $error("predictive failure code lost");
endmodule : hpt_monitor
`default_nettype wire

//--- dv/hpt_host_model.sv
// Host-side model that finishes each medium save after a short delay
`timescale 1ns/10ps
`default_nettype none
module hpt_host_model #(
    parameter int LAT = 3
) (
    input  wire logic i_clock,
    input  wire logic i_save_req,
    output logic      o_save_done
);
    int cnt = 0;
    // One-cycle done pulse; count restarts for every new request
    always @(posedge i_clock)
    begin
        o_save_done <= (cnt == LAT);
        cnt <= (i_save_req && cnt <= LAT) ? cnt + 1 : 0;
    end
endmodule // hpt_host_model
`default_nettype wire

//--- dv/hpt_monitor_test.sv
// Testbench for the health predict and thermal monitor
`timescale 1ns/10ps
`default_nettype none
module hpt_monitor_test;
    import hpt_pkg::*;
    logic clk = 0, rst_b = 0, dis = 0, onl = 0, wen = 1, rz = 0;
    logic hb = 0, nvp = 0, nvt_v = 0;
    logic [7:0] nvp_t = 8'h00, nvt = 8'h00, ts;
    logic [31:0] tl;
    logic lw = 0, ack = 0, sreq, sdone, sv, pf;
    logic [3:0] meth = 4'h1, op = 4'h0, er = 4'h0;
    logic [15:0] lp = 16'h0000, ivl = 16'h0008, elim = 16'h0001;
    logic [15:0] plim = 16'h0002;
    logic [7:0] ld = 8'h00, tp = 8'h20, trip, unit;
    logic [23:0] code;
    int err_count = 0, n_tests = 0;
    always #10 clk = ~clk;
    hpt_monitor #(.SAVE_CYC(200), .TEMP_CYC(50), .STALL_ONLINE_CYC(10),
        .STALL_FULL_CYC(10)) DUT (
        .i_clock(clk), .i_rst_b(rst_b), .i_monitor_disable(dis),
        .i_online_only_select(onl), .i_exception_report_method(meth),
        .i_temp_warning_enable(wen), .i_attr_op(op), .i_attr_err(er),
        .i_interval(ivl), .i_err_limit(elim), .i_predict_limit(plim),
        .i_host_busy(hb), .i_rezero_force_save(rz), .i_save_done(sdone),
        .i_nv_pf_valid(nvp), .i_nv_pf_type(nvp_t), .i_nv_trip_valid(nvt_v),
        .i_nv_trip(nvt), .i_temp_pin(tp), .i_log_write(lw),
        .i_log_param(lp), .i_log_data(ld), .i_sense_ack(ack),
        .o_save_req(sreq), .o_offline_run(), .o_time_left(tl),
        .o_nv_pf_write(), .o_nv_pf_type(), .o_nv_trip_write(),
        .o_user_trip(trip), .o_temp_sample(ts), .o_sense_valid(sv),
        .o_sense_code(code), .o_sense_unit(unit), .o_pf_active(pf));
    hpt_host_model #(.LAT(20)) HOST (.i_clock(clk), .i_save_req(sreq),
        .o_save_done(sdone));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wait_sense;
        for (int i = 0; i < 100 && sv !== 1'b1; i++) tick(1);
    endtask
    task ack_sense;
        ack = 1;
        tick(1);
        ack = 0;
        tick(1);
    endtask
    task log_wr(input logic [15:0] p, input logic [7:0] d);
        lp = p;
        ld = d;
        lw = 1;
        tick(1);
        lw = 0;
        tick(1);
    endtask
    task rezero;
        rz = 1;
        tick(1);
        rz = 0;
        tick(1);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        tick(8);
        rst_b = 1;
        tick(2);
        check("trip", trip, TRIP_RESET);
        check("pf", pf, 1'b0);
        log_wr(PARAM_REFERENCE, 8'h30);
        check("trip", trip, 8'h30);
        check("temp", ts, 8'h20);
        log_wr(PARAM_PRIMARY, 8'h10);
        check("trip", trip, 8'h30);
        log_wr(PARAM_REFERENCE, 8'h50);
        check("trip", trip, TRIP_RESET);
        check("code", code, SENSE_ROUNDED);
        ack_sense;
        dis = 1;
        rezero;
        check("save", sreq, 1'b0);
        dis = 0;
        onl = 1;
        rezero;
        check("save", sreq, 1'b0);
        onl = 0;
        rezero;
        check("save", sreq, 1'b1);
        check("left", tl, 32'h0);
        tick(25);
        check("save", sreq, 1'b0);
        // Host stays busy past the stall limit, so the save must yield
        hb = 1;
        rezero;
        check("save", sreq, 1'b1);
        tick(12);
        check("save", sreq, 1'b0);
        hb = 0;
        tick(1);
        check("save", sreq, 1'b1);
        tick(25);
        check("save", sreq, 1'b0);
        // Two bad intervals on attribute 0, idle gap so each closes cleanly
        repeat (2)
        begin
            op = 4'h1;
            er = 4'h1;
            tick(2);
            op = 4'h0;
            er = 4'h0;
            tick(2);
        end
        wait_sense;
        check("code", code, SENSE_PREDICT);
        check("unit", unit, 8'h01);
        check("pf", pf, 1'b1);
        ack_sense;
        wen = 0;
        tp = 8'h50;
        tick(60);
        check("valid", sv, 1'b0);
        wen = 1;
        meth = 4'h2;
        tick(50);
        check("valid", sv, 1'b0);
        meth = 4'h1;
        wait_sense;
        check("code", code, SENSE_TEMP);
        check("unit", unit, 8'h50);
        tick(2);
        check("save", sreq, 1'b1);
        // Second reset with saved trip point and failure code present
        rst_b = 0;
        nvp = 1;
        nvp_t = 8'h03;
        nvt_v = 1;
        nvt = 8'h28;
        tick(2);
        rst_b = 1;
        tick(2);
        check("trip", trip, 8'h28);
        check("pf", pf, 1'b1);
        print_verdict;
    end
    initial
    begin
        #(20 * 3000);
        err_count++;
        print_verdict;
    end
endmodule // hpt_monitor_test
`default_nettype wire
